// file: rtl/port_dir_defines.svh
// offsets, field widths, reset values and the bridge count for the port block
`ifndef PORT_DIR_DEFINES_SVH
`define PORT_DIR_DEFINES_SVH
`define GPIO_DATA_OFF 8'h00
`define GPIO_DIR_OFF 8'h04
`define PE_DATA_OFF 8'h40
`define PF_DATA_OFF 8'h42
`define PE_SEL_OFF 8'h44
`define PF_SEL_OFF 8'h45
`define PE_SIGN_OFF 8'h46
`define PWM_DUTY0_OFF 8'h48
`define PWM_DUTY3_OFF 8'h4B
`define PE_STATUS_OFF 8'h4C
`define GPIO_DIR_RST 8'h00
`define PE_DATA_RST 8'h00
`define PF_DATA_RST 4'h0
`define PE_WIDTH 8
`define PF_WIDTH 4
`define BRIDGE_CNT 4
`endif

// file: rtl/port_dir_pkg.sv
// types for the port block
package port_dir_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef enum logic [1:0] {
    PH_LOW = 2'b01,
    PH_HIGH = 2'b10
  } pwm_phase_t;
endpackage : port_dir_pkg

// file: rtl/port_direction_and_hbridge_sign.sv
// general port with direction bits plus power-driver ports with h-bridge sign control
//
// Function
// - direction one drives pin, zero reads
// - reset clears all direction bits
// - direction bits writable and readable
// - write with direction zero loads latch only
// - write with direction one drives pin
// - read returns pin level for inputs
// - read returns latch for outputs
// - read-modify-write stores result into latch
// - wait option forces driver ports low
// - sign swaps pulse and static, inverts
// - sign plus eight bits two's complement
// - negative values invert the pulse pattern
// - per-bit select routes latch or pulse
// - reset clears both driver data latches
//
// Chosen here: the plain strobed port and the register offsets.
`include "port_dir_defines.svh"
module port_direction_and_hbridge_sign
  import port_dir_pkg::*;
#(
  parameter int GPIO_WIDTH = 8,
  parameter bit WAIT_FORCE_LOW = 1'b1
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic wait_mode_in,
  input wire logic [GPIO_WIDTH-1:0] gpio_pin_in,
  output logic [GPIO_WIDTH-1:0] gpio_pin_out,
  output logic [GPIO_WIDTH-1:0] gpio_oe_n_out,
  output logic [`PE_WIDTH-1:0] pe_pin_out,
  output logic [`PF_WIDTH-1:0] pf_pin_out,
  output logic [7:0] rdata_out
);

  bus_req_t req;
  logic [GPIO_WIDTH-1:0] dir_q;
  logic [GPIO_WIDTH-1:0] latch_q;
  logic [`PE_WIDTH-1:0] pe_data_q;
  logic [`PF_WIDTH-1:0] pf_data_q;
  logic [`PE_WIDTH-1:0] pe_sel_q;
  logic [`PF_WIDTH-1:0] pf_sel_q;
  logic [`BRIDGE_CNT-1:0] sign_q;
  logic [7:0] duty_q [`BRIDGE_CNT];
  logic [7:0] pwm_cnt_q;
  logic [`BRIDGE_CNT-1:0] pulse;
  logic [`PE_WIDTH-1:0] pe_d;
  logic [`PF_WIDTH-1:0] pf_d;
  logic [GPIO_WIDTH-1:0] port_view;
  logic [7:0] rdata_d;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // per-bit view of the port data location
  genvar gi;
  generate
    for (gi = 0; gi < GPIO_WIDTH; gi++) begin : g_bit
      assign port_view[gi] = dir_q[gi] ? latch_q[gi] : gpio_pin_in[gi];
    end
  endgenerate

  // direction register
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      dir_q <= GPIO_WIDTH'(`GPIO_DIR_RST);
    end else if (clk_en_in && req.wr && req.addr == `GPIO_DIR_OFF) begin
      dir_q <= req.wdata[GPIO_WIDTH-1:0];
    end
  end

  // output data latch, written regardless of direction
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      latch_q <= '0;
    end else if (clk_en_in && req.wr && req.addr == `GPIO_DATA_OFF) begin
      latch_q <= req.wdata[GPIO_WIDTH-1:0];
    end
  end

  // pin drivers follow the direction bits
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      gpio_pin_out <= '0;
      gpio_oe_n_out <= '1;
    end else if (clk_en_in) begin
      gpio_oe_n_out <= ~dir_q;
      gpio_pin_out <= latch_q;
    end
  end

  // power-driver data latches and routing controls
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      pe_data_q <= `PE_DATA_RST;
      pf_data_q <= `PF_DATA_RST;
      pe_sel_q <= '0;
      pf_sel_q <= '0;
      sign_q <= '0;
    end else if (clk_en_in && req.wr) begin
      unique case (req.addr)
        `PE_DATA_OFF: pe_data_q <= req.wdata;
        `PF_DATA_OFF: pf_data_q <= req.wdata[`PF_WIDTH-1:0];
        `PE_SEL_OFF: pe_sel_q <= req.wdata;
        `PF_SEL_OFF: pf_sel_q <= req.wdata[`PF_WIDTH-1:0];
        `PE_SIGN_OFF: sign_q <= req.wdata[`BRIDGE_CNT-1:0];
        default: ;
      endcase
    end
  end

  // duty registers for the bridge channels
  generate
    for (gi = 0; gi < `BRIDGE_CNT; gi++) begin : g_duty
      always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
          duty_q[gi] <= 8'h00;
        end else if (clk_en_in && req.wr && req.addr == 8'(`PWM_DUTY0_OFF + gi)) begin
          duty_q[gi] <= req.wdata;
        end
      end
    end
  endgenerate

  // free-running period counter shared by the bridges
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      pwm_cnt_q <= 8'h00;
    end else if (clk_en_in) begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
    end
  end

  // bridge pulse: sign plus duty forms a nine bit two's complement value
  generate
    for (gi = 0; gi < `BRIDGE_CNT; gi++) begin : g_pulse
      assign pulse[gi] = (pwm_cnt_q < duty_q[gi]) ^ sign_q[gi];
    end
  endgenerate

  // route pulse or static drive onto the driver pins
  always_comb begin
    pe_d = pe_data_q;
    pf_d = pf_data_q;
    for (int b = 0; b < `BRIDGE_CNT / 2; b++) begin
      if (pe_sel_q[2*b]) begin
        pe_d[2*b] = sign_q[b] ? pe_data_q[2*b] : pulse[b];
      end
      if (pe_sel_q[2*b+1]) begin
        pe_d[2*b+1] = sign_q[b] ? pulse[b] : pe_data_q[2*b+1];
      end
    end
    for (int b = 2; b < `BRIDGE_CNT; b++) begin
      if (pe_sel_q[2*b]) begin
        pe_d[2*b] = sign_q[b] ? pe_data_q[2*b] : pulse[b];
      end
      if (pe_sel_q[2*b+1]) begin
        pe_d[2*b+1] = sign_q[b] ? pulse[b] : pe_data_q[2*b+1];
      end
    end
    for (int b = 0; b < `PF_WIDTH; b++) begin
      if (pf_sel_q[b]) begin
        pf_d[b] = pulse[b];
      end
    end
    if (WAIT_FORCE_LOW && wait_mode_in) begin
      pe_d = '0;
      pf_d = '0;
    end
  end

  // registered driver outputs
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      pe_pin_out <= '0;
      pf_pin_out <= '0;
    end else if (clk_en_in) begin
      pe_pin_out <= pe_d;
      pf_pin_out <= pf_d;
    end
  end

  // read decode, unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (req.addr == `GPIO_DATA_OFF) begin
      rdata_d[GPIO_WIDTH-1:0] = port_view;
    end else if (req.addr == `GPIO_DIR_OFF) begin
      rdata_d[GPIO_WIDTH-1:0] = dir_q;
    end else if (req.addr == `PE_DATA_OFF) begin
      rdata_d = pe_data_q;
    end else if (req.addr == `PF_DATA_OFF) begin
      rdata_d[`PF_WIDTH-1:0] = pf_data_q;
    end else if (req.addr == `PE_SEL_OFF) begin
      rdata_d = pe_sel_q;
    end else if (req.addr == `PF_SEL_OFF) begin
      rdata_d[`PF_WIDTH-1:0] = pf_sel_q;
    end else if (req.addr == `PE_SIGN_OFF) begin
      rdata_d[`BRIDGE_CNT-1:0] = sign_q;
    end else if (req.addr >= `PWM_DUTY0_OFF && req.addr <= `PWM_DUTY3_OFF) begin
      rdata_d = duty_q[req.addr[1:0]];
    end else if (req.addr == `PE_STATUS_OFF) begin
      rdata_d = pe_pin_out;
    end
  end

  // read data register, valid the cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      rdata_out <= req.rd ? rdata_d : 8'h00;
    end
  end

  // checks
  property p_dir_reset;
    @(posedge sys_clk_in) !resetn_in |=> dir_q == 8'h00;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");

  property p_oe;
    @(posedge sys_clk_in) disable iff (!resetn_in) clk_en_in |=> gpio_oe_n_out == ~$past(dir_q);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable mismatch");

  property p_latch;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      clk_en_in && wr_in && addr_in == `GPIO_DATA_OFF |=> latch_q == $past(wdata_in);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not written");

  // a port data write taken while the clock runs
  sequence s_data_wr;
    clk_en_in && wr_in && addr_in == `GPIO_DATA_OFF;
  endsequence

  // a cycle with the clock running
  sequence s_run;
    clk_en_in;
  endsequence

  property p_drive;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      s_data_wr ##1 s_run |=> gpio_pin_out == $past(latch_q);
  endproperty
  a_drive: assert property (p_drive) else $error("pin not driven");

  property p_rd_in;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      clk_en_in && rd_in && addr_in == `GPIO_DATA_OFF |=> rdata_out == $past(port_view);
  endproperty
  a_rd_in: assert property (p_rd_in) else $error("port read wrong");

  property p_rd_dir;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      clk_en_in && rd_in && addr_in == `GPIO_DIR_OFF |=> rdata_out == $past(dir_q);
  endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("direction read wrong");

  property p_wait;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      clk_en_in && wait_mode_in && WAIT_FORCE_LOW |=> pe_pin_out == 8'h00 && pf_pin_out == 4'h0;
  endproperty
  a_wait: assert property (p_wait) else $error("wait drive not low");

  property p_pe_reset;
    @(posedge sys_clk_in) !resetn_in |=> pe_data_q == 8'h00 && pf_data_q == 4'h0;
  endproperty
  a_pe_reset: assert property (p_pe_reset) else $error("driver latch not cleared");

  property p_dir_write;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      clk_en_in && wr_in && addr_in == `GPIO_DIR_OFF |=> dir_q == $past(wdata_in);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not written");

  property p_rd_pin;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      clk_en_in && rd_in && addr_in == `GPIO_DATA_OFF && dir_q == '0 |=> rdata_out == $past(gpio_pin_in);
  endproperty
  a_rd_pin: assert property (p_rd_pin) else $error("input pin read wrong");

  property p_rd_latch;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      clk_en_in && rd_in && addr_in == `GPIO_DATA_OFF && dir_q == '1 |=> rdata_out == $past(latch_q);
  endproperty
  a_rd_latch: assert property (p_rd_latch) else $error("output read not latch");

  property p_right_static;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      clk_en_in && !wait_mode_in && pe_sel_q[1] && !sign_q[0] |=> pe_pin_out[1] == $past(pe_data_q[1]);
  endproperty
  a_right_static: assert property (p_right_static) else $error("right line not static");

  property p_left_static;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      clk_en_in && !wait_mode_in && pe_sel_q[0] && sign_q[0] |=> pe_pin_out[0] == $past(pe_data_q[0]);
  endproperty
  a_left_static: assert property (p_left_static) else $error("left line not static");

  property p_freeze;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      !clk_en_in |=> $stable(dir_q) && $stable(latch_q) && $stable(rdata_out) && $stable(pe_pin_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // port F lines checked one by one
  generate
    for (gi = 0; gi < `PF_WIDTH; gi++) begin : g_pf_chk
      property p_pf_pulse;
        @(posedge sys_clk_in) disable iff (!resetn_in)
          clk_en_in && !wait_mode_in && pf_sel_q[gi] |=>
            pf_pin_out[gi] == ($past(sign_q[gi]) ? ($past(pwm_cnt_q) >= $past(duty_q[gi]))
                                                 : ($past(pwm_cnt_q) < $past(duty_q[gi])));
      endproperty
      a_pf_pulse: assert property (p_pf_pulse) else $error("port F pulse wrong");
      property p_pf_static;
        @(posedge sys_clk_in) disable iff (!resetn_in)
          clk_en_in && !wait_mode_in && !pf_sel_q[gi] |=> pf_pin_out[gi] == $past(pf_data_q[gi]);
      endproperty
      a_pf_static: assert property (p_pf_static) else $error("port F static wrong");
    end
  endgenerate

endmodule : port_direction_and_hbridge_sign

// file: tb/pin_model.sv
// model of the pins at the far side of the general port
module pin_model (
  input wire logic [7:0] drive_in,
  input wire logic [7:0] oe_n_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin shows the port drive, an undriven one the outside level
  assign level_out = (oe_n_in & ext_in) | (~oe_n_in & drive_in);
endmodule : pin_model

// file: tb/tb.sv
// self-checking testbench for the port direction and bridge sign block
`include "port_dir_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic wait_mode_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] ext = 8'h3C;
  logic [7:0] pins;
  logic [7:0] gpio_pin_out;
  logic [7:0] gpio_oe_n_out;
  logic [7:0] pe_pin_out;
  logic [3:0] pf_pin_out;
  logic [7:0] rdata_out;
  int fail_count = 0;
  int checks = 0;
  // 200 MHz clock
  always #2.5 sys_clk_in = ~sys_clk_in;
  pin_model pin_model_inst (.drive_in(gpio_pin_out), .oe_n_in(gpio_oe_n_out), .ext_in(ext), .level_out(pins));
  port_direction_and_hbridge_sign port_direction_and_hbridge_sign_inst (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .wait_mode_in(wait_mode_in),
    .gpio_pin_in(pins), .gpio_pin_out(gpio_pin_out), .gpio_oe_n_out(gpio_oe_n_out),
    .pe_pin_out(pe_pin_out), .pf_pin_out(pf_pin_out), .rdata_out(rdata_out));
  // compare one byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // read, data judged in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask : rd
  // let registered outputs follow
  task automatic settle();
    repeat (3) @(posedge sys_clk_in);
    #1;
  endtask : settle
  // state after reset
  task automatic t_reset();
    rd(`GPIO_DIR_OFF, 8'h00);
    rd(`GPIO_DATA_OFF, 8'h3C);
    chk(gpio_oe_n_out, 8'hFF);
    rd(`PE_DATA_OFF, 8'h00);
    chk({4'h0, pf_pin_out}, 8'h00);
  endtask : t_reset
  // write with all pins as inputs, then half outputs
  task automatic t_dir();
    wr(`GPIO_DATA_OFF, 8'hA5);
    settle();
    chk(gpio_oe_n_out, 8'hFF);
    rd(`GPIO_DATA_OFF, 8'h3C);
    wr(`GPIO_DIR_OFF, 8'hF0);
    settle();
    rd(`GPIO_DIR_OFF, 8'hF0);
    chk(gpio_oe_n_out, 8'h0F);
    chk(gpio_pin_out & 8'hF0, 8'hA0);
    rd(`GPIO_DATA_OFF, 8'hAC);
  endtask : t_dir
  // read-modify-write on input pins lands in the latch
  task automatic t_read_modify_write();
    wr(`GPIO_DIR_OFF, 8'h00);
    ext <= 8'h5A;
    rd(`GPIO_DATA_OFF, 8'h5A);
    wr(`GPIO_DATA_OFF, 8'h5A | 8'h81);
    wr(`GPIO_DIR_OFF, 8'hFF);
    settle();
    rd(`GPIO_DATA_OFF, 8'hDB);
    chk(gpio_pin_out, 8'hDB);
  endtask : t_read_modify_write
  // sign swaps pulse and static lines of bridge 0, duty zero
  task automatic t_bridge();
    wr(`PE_DATA_OFF, 8'h01);
    wr(`PE_SEL_OFF, 8'h03);
    wr(`PWM_DUTY0_OFF, 8'h00);
    wr(`PE_SIGN_OFF, 8'h00);
    settle();
    chk(pe_pin_out, 8'h00);
    wr(`PE_SIGN_OFF, 8'h01);
    settle();
    rd(`PE_STATUS_OFF, 8'h03);
    wr(`PF_SEL_OFF, 8'h00);
    wr(`PF_DATA_OFF, 8'h05);
    settle();
    chk({4'h0, pf_pin_out}, 8'h05);
  endtask : t_bridge
  // wait mode forces driver ports low
  task automatic t_wait();
    @(posedge sys_clk_in);
    wait_mode_in <= 1'b1;
    settle();
    chk({pf_pin_out, pe_pin_out[3:0]}, 8'h00);
    @(posedge sys_clk_in);
    wait_mode_in <= 1'b0;
    settle();
    chk({4'h0, pf_pin_out}, 8'h05);
  endtask : t_wait
  // frozen clock enable and unmapped read
  task automatic t_misc();
    @(posedge sys_clk_in);
    clk_en_in <= 1'b0;
    wr(`GPIO_DIR_OFF, 8'h00);
    clk_en_in <= 1'b1;
    rd(`GPIO_DIR_OFF, 8'hFF);
    rd(8'h10, 8'h00);
  endtask : t_misc
  // count high cycles of port F bit 1 over one full pulse period
  task automatic count_pulse(output logic [7:0] n);
    n = 8'h00;
    repeat (256) begin
      @(posedge sys_clk_in);
      #1;
      if (pf_pin_out[1] === 1'b1) begin
        n = n + 8'h01;
      end
    end
  endtask : count_pulse
  // pulse ratio of channel 1 on port F, positive then negative value
  task automatic t_pulse();
    logic [7:0] n;
    wr(`PF_SEL_OFF, 8'h02);
    wr(`PWM_DUTY0_OFF + 8'h01, 8'h40);
    // sign set first, held through each measurement
    wr(`PE_SIGN_OFF, 8'h00);
    settle();
    count_pulse(n);
    chk(n, 8'h40);
    wr(`PE_SIGN_OFF, 8'h02);
    settle();
    count_pulse(n);
    chk(n, 8'hC0);
    chk({4'h0, pf_pin_out} & 8'h0D, 8'h05);
  endtask : t_pulse
  // reset in mid-run clears direction and the port E data latch again
  task automatic t_rereset();
    wr(`PE_DATA_OFF, 8'hC3);
    @(posedge sys_clk_in);
    resetn_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    #1 chk(gpio_oe_n_out, 8'hFF);
    rd(`GPIO_DIR_OFF, 8'h00);
    rd(`PE_DATA_OFF, 8'h00);
    chk(pe_pin_out, 8'h00);
  endtask : t_rereset
  // verdict and end of run
  task automatic end_of_test();
    $display("fail_count=%0d checks=%0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_dir();
    t_read_modify_write();
    t_bridge();
    t_wait();
    t_pulse();
    t_misc();
    t_rereset();
    end_of_test();
  end
  // watchdog
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
endmodule : tb
